// >>> common/fpe_defines.svh
// Address map, bit positions, reset values and timing counts of the flash sequencer
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

`define FPE_FCR_ADDR      24'h22_4000
`define FPE_FCR_ALIAS     24'h22_1000
`define FPE_ECR_ADDR      24'h22_4001
`define FPE_ECR_ALIAS     24'h22_1001
`define FPE_FCR_RESET     8'h00

`define FPE_B_START       7
`define FPE_B_PAGE        6
`define FPE_B_CHIP        5
`define FPE_B_BYTE        4
`define FPE_B_SECT        3
`define FPE_B_SUSP        2
`define FPE_B_PROTECTION_SET_SELECT        1
`define FPE_B_BUSY        0
`define FPE_B_WAIT_LOWPOWER_SELECT        2
`define FPE_B_ISRC        1
`define FPE_B_EEPROM_BUSY_FLAG       0

`define FPE_MAIN_END      24'h03_FFFF
`define FPE_SECT1_BASE    24'h00_2000
`define FPE_SECT2_BASE    24'h00_4000
`define FPE_SECT3_BASE    24'h01_0000
`define FPE_SECT4_BASE    24'h02_0000
`define FPE_SECT5_BASE    24'h03_0000
`define FPE_SYS_BASE      24'h23_0000
`define FPE_SYS_END       24'h23_1FFF
`define FPE_PROTECTION_SET_SELECT_BASE     24'h23_1FFC
`define FPE_NO_SECT       3'h7
`define FPE_ALL_SECT      6'h3F

`define FPE_BLANK         8'hFF
`define FPE_PREPROG_DATA  8'h00
`define FPE_ERASE_DATA    8'hFF
`define FPE_PAGE_BYTES    16
`define FPE_SECTORS       6

`define FPE_CLK_NS        4
`define FPE_SUSP_MAX_NS   15000
`define FPE_PWRUP_MAX_NS  10000
`define FPE_SUSP_CYC      (`FPE_SUSP_MAX_NS / `FPE_CLK_NS)
`define FPE_PWRUP_CYC     (`FPE_PWRUP_MAX_NS / `FPE_CLK_NS)

`endif

// >>> common/fpe_pkg.sv
// Types shared by the flash sequencer modules
package fpe_pkg;

  typedef enum logic [2:0] {ARR_NONE, ARR_PROG, ARR_PREPROG, ARR_ERASE, ARR_ABORT} fpe_arr_op_t;

  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_LOAD, ST_PG_READ, ST_PG_WAIT,
    ST_PREPROG, ST_PREPROG_WAIT, ST_ERASE_WAIT, ST_SUSP_WAIT, ST_SUSPENDED
  } fpe_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } fpe_cpu_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } fpe_cpu_rsp_t;

  typedef struct packed {
    fpe_arr_op_t op;
    logic [23:0] addr;
    logic [7:0]  data;
    logic [2:0]  sector;
  } fpe_arr_cmd_t;

  typedef struct packed {
    logic [11:0] count;
    logic        run;
    logic        expired;
  } fpe_tmr_t;

  typedef struct packed {
    fpe_state_t        state;
    logic              start;
    logic              page_pgm;
    logic              chip_ers;
    logic              byte_pgm;
    logic              sect_ers;
    logic              susp;
    logic              protection_set_select;
    logic              wait_lowpower_select;
    logic              isrc;
    logic [15:0][7:0]  buf_data;
    logic [15:0]       buf_mask;
    logic [23:0]       page_base;
    logic [5:0]        sect_mask;
    logic [2:0]        cur_sect;
    logic              in_susp;
    logic [3:0]        idx;
    fpe_arr_cmd_t      cmd;
    fpe_cpu_rsp_t      rsp;
    logic              eow;
    logic              pd_q;
    logic              tmr_start;
    logic [11:0]       tmr_cycles;
  } fpe_ctrl_t;

endpackage : fpe_pkg

// >>> src/fpe_timer.sv
// Down-counter that times power-up readiness and the suspend limit
`timescale 1ns/1ns
`include "fpe_defines.svh"
module fpe_timer import fpe_pkg::*; (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // Control
  input  wire logic        i_start,
  input  wire logic [11:0] i_cycles,
  // Status
  output logic             o_running,
  output logic             o_expired
);

  fpe_tmr_t s_ff;
  fpe_tmr_t nxt_s;

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.expired = 1'b0;
    // Expiry is registered and a start lands a cycle late, so both are taken off the count
    if (i_start) begin
      nxt_s.count = i_cycles - 12'h001;
      nxt_s.run   = 1'b1;
    end else if (s_ff.run) begin
      if (s_ff.count <= 12'h002) begin
        nxt_s.run     = 1'b0;
        nxt_s.expired = 1'b1;
      end else begin
        nxt_s.count = s_ff.count - 12'h001;
      end
    end
  end

  // Out of reset the timer already runs, so the power-up wait needs no start
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s_ff.count   <= 12'(`FPE_PWRUP_CYC);
      s_ff.run     <= 1'b1;
      s_ff.expired <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_running = s_ff.run;
  assign o_expired = s_ff.expired;

endmodule : fpe_timer

// >>> src/fpe_flash_ctrl.sv
// Flash program and erase sequencer with its control registers
`timescale 1ns/1ns
`include "fpe_defines.svh"
module fpe_flash_ctrl import fpe_pkg::*; (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_reset,
  // CPU access
  input  wire fpe_cpu_req_t  i_req,
  output fpe_cpu_rsp_t       o_rsp,
  // Flash array
  output fpe_arr_cmd_t       o_arr_cmd,
  output logic [23:0]        o_arr_raddr,
  input  wire logic [7:0]    i_arr_rdata,
  input  wire logic          i_arr_done,
  // System
  input  wire logic          i_eeprom_busy,
  input  wire logic          i_powerdown,
  input  wire logic          i_ext_int,
  output logic               o_busy,
  output logic               o_int,
  output logic               o_wfi_powerdown,
  output logic               o_eeprom_update_refuse,
  output logic               o_flash_write_active
);

  fpe_ctrl_t   s_ff;
  fpe_ctrl_t   nxt_s;
  logic        busy;
  logic        running;
  logic        fcr_hit;
  logic        ecr_hit;
  logic        flash_hit;
  logic        protection_set_select_hit;
  logic        store;
  logic        start_req;
  logic        same_page;
  logic        accept;
  logic        pg_done;
  logic        ers_done;
  logic [2:0]  st_sect;
  logic [7:0]  fcr_val;
  logic [7:0]  ecr_val;
  logic        tmr_expired;

  function automatic logic [2:0] sector_of(input logic [23:0] a);
    if (a < `FPE_SECT1_BASE)     sector_of = 3'h0;
    else if (a < `FPE_SECT2_BASE) sector_of = 3'h1;
    else if (a < `FPE_SECT3_BASE) sector_of = 3'h2;
    else if (a < `FPE_SECT4_BASE) sector_of = 3'h3;
    else if (a < `FPE_SECT5_BASE) sector_of = 3'h4;
    else if (a <= `FPE_MAIN_END)  sector_of = 3'h5;
    else                          sector_of = `FPE_NO_SECT;
  endfunction : sector_of

  function automatic logic [3:0] lowest(input logic [15:0] m);
    lowest = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) lowest = 4'(i);
    end
  endfunction : lowest

  fpe_timer u_timer (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_start    (s_ff.tmr_start),
    .i_cycles   (s_ff.tmr_cycles),
    .o_running  (),
    .o_expired  (tmr_expired)
  );

  assign busy      = (s_ff.state != ST_IDLE) && (s_ff.state != ST_SUSPENDED);
  assign running   = busy && (s_ff.state != ST_LOAD) && (s_ff.state != ST_PWRUP);
  assign fcr_hit   = (i_req.addr == `FPE_FCR_ADDR) || (i_req.addr == `FPE_FCR_ALIAS);
  assign ecr_hit   = (i_req.addr == `FPE_ECR_ADDR) || (i_req.addr == `FPE_ECR_ALIAS);
  assign flash_hit = (i_req.addr <= `FPE_MAIN_END) ||
                     ((i_req.addr >= `FPE_SYS_BASE) && (i_req.addr <= `FPE_SYS_END));
  assign protection_set_select_hit  = (i_req.addr >= `FPE_PROTECTION_SET_SELECT_BASE) && (i_req.addr <= `FPE_SYS_END);
  assign st_sect   = sector_of(i_req.addr);
  assign store     = i_req.wr && flash_hit;
  assign start_req = i_req.wr && fcr_hit && i_req.wdata[`FPE_B_START] && !i_eeprom_busy;
  assign same_page = (s_ff.state != ST_LOAD) || (i_req.addr[23:4] == s_ff.page_base[23:4]);
  assign fcr_val   = {s_ff.start, s_ff.page_pgm, s_ff.chip_ers, s_ff.byte_pgm,
                      s_ff.sect_ers, s_ff.susp, s_ff.protection_set_select, busy};
  assign ecr_val   = {5'h00, s_ff.wait_lowpower_select, s_ff.isrc, i_eeprom_busy};

  // Stores are taken only by the select that owns them; anything else is dropped
  always_comb begin
    accept = 1'b0;
    if (store) begin
      unique case (s_ff.state)
        ST_IDLE, ST_LOAD: begin
          if ((s_ff.page_pgm || s_ff.byte_pgm) && st_sect != `FPE_NO_SECT && same_page) accept = 1'b1;
          if (s_ff.protection_set_select && protection_set_select_hit && same_page) accept = 1'b1;
          if (s_ff.sect_ers && st_sect != `FPE_NO_SECT) accept = 1'b1;
        end
        ST_SUSPENDED: begin
          accept = s_ff.byte_pgm && st_sect != `FPE_NO_SECT && st_sect != s_ff.cur_sect;
        end
        default: accept = 1'b0;
      endcase
    end
  end

  always_comb begin
    nxt_s            = s_ff;
    nxt_s.cmd        = '0;
    nxt_s.eow        = 1'b0;
    nxt_s.tmr_start  = 1'b0;
    nxt_s.pd_q       = i_powerdown;
    pg_done          = 1'b0;
    ers_done         = 1'b0;

    nxt_s.rsp.rvalid = i_req.rd;
    if (fcr_hit) nxt_s.rsp.rdata = fcr_val;
    else if (ecr_hit) nxt_s.rsp.rdata = ecr_val;
    else if (flash_hit) nxt_s.rsp.rdata = busy ? `FPE_BLANK : i_arr_rdata;
    else nxt_s.rsp.rdata = 8'h00;

    if (i_req.wr && ecr_hit) begin
      nxt_s.wait_lowpower_select = i_req.wdata[`FPE_B_WAIT_LOWPOWER_SELECT];
      nxt_s.isrc = i_req.wdata[`FPE_B_ISRC];
    end
    if (i_req.wr && fcr_hit) begin
      nxt_s.susp = i_req.wdata[`FPE_B_SUSP];
      if (!running) begin
        nxt_s.start    = i_req.wdata[`FPE_B_START] && !i_eeprom_busy;
        nxt_s.page_pgm = i_req.wdata[`FPE_B_PAGE];
        nxt_s.chip_ers = i_req.wdata[`FPE_B_CHIP];
        nxt_s.byte_pgm = i_req.wdata[`FPE_B_BYTE];
        nxt_s.sect_ers = i_req.wdata[`FPE_B_SECT];
        nxt_s.protection_set_select     = i_req.wdata[`FPE_B_PROTECTION_SET_SELECT];
      end
    end

    // Sector selection keeps the data out of the page buffer, except for a byte program while suspended
    if (accept) begin
      if (s_ff.sect_ers && !s_ff.in_susp) begin
        nxt_s.sect_mask[st_sect] = 1'b1;
      end else begin
        nxt_s.page_base = i_req.addr;
        nxt_s.buf_mask  = ((s_ff.state == ST_LOAD) ? s_ff.buf_mask : 16'h0000) |
                          (16'h0001 << i_req.addr[3:0]);
        nxt_s.buf_data[i_req.addr[3:0]] = i_req.wdata;
      end
      nxt_s.state = ST_LOAD;
    end

    unique case (s_ff.state)
      ST_PWRUP: begin
        if (tmr_expired) nxt_s.state = ST_IDLE;
      end
      ST_IDLE: begin
        if (s_ff.pd_q && !i_powerdown) begin
          nxt_s.tmr_start  = 1'b1;
          nxt_s.tmr_cycles = 12'(`FPE_PWRUP_CYC);
          nxt_s.state      = ST_PWRUP;
        end else if (start_req && nxt_s.chip_ers) begin
          nxt_s.sect_mask = `FPE_ALL_SECT;
          nxt_s.cur_sect  = 3'h0;
          nxt_s.state     = ST_PREPROG;
        end else if (start_req) begin
          nxt_s.start = 1'b0;
        end
      end
      ST_LOAD: begin
        if (start_req) begin
          if (nxt_s.sect_ers && !s_ff.in_susp) begin
            nxt_s.cur_sect = 3'(lowest({10'h000, s_ff.sect_mask}));
            nxt_s.state    = ST_PREPROG;
          end else begin
            nxt_s.idx   = lowest(s_ff.buf_mask);
            nxt_s.state = ST_PG_READ;
          end
        end
      end
      ST_PG_READ: begin
        nxt_s.cmd.op   = ARR_PROG;
        nxt_s.cmd.addr = {s_ff.page_base[23:4], s_ff.idx};
        nxt_s.cmd.data = s_ff.buf_data[s_ff.idx] & i_arr_rdata;
        nxt_s.state    = ST_PG_WAIT;
      end
      ST_PG_WAIT: begin
        if (i_arr_done) begin
          nxt_s.buf_mask[s_ff.idx] = 1'b0;
          if (nxt_s.buf_mask == 16'h0000) begin
            pg_done = 1'b1;
          end else begin
            nxt_s.idx   = lowest(nxt_s.buf_mask);
            nxt_s.state = ST_PG_READ;
          end
        end
      end
      ST_PREPROG: begin
        nxt_s.cmd.op     = ARR_PREPROG;
        nxt_s.cmd.sector = s_ff.cur_sect;
        nxt_s.cmd.data   = `FPE_PREPROG_DATA;
        nxt_s.state      = ST_PREPROG_WAIT;
      end
      ST_PREPROG_WAIT, ST_ERASE_WAIT: begin
        if (s_ff.sect_ers && !s_ff.chip_ers && nxt_s.susp) begin
          nxt_s.cmd.op     = ARR_ABORT;
          nxt_s.tmr_start  = 1'b1;
          nxt_s.tmr_cycles = 12'(`FPE_SUSP_CYC);
          nxt_s.state      = ST_SUSP_WAIT;
        end else if (i_arr_done && s_ff.state == ST_PREPROG_WAIT) begin
          nxt_s.cmd.op     = ARR_ERASE;
          nxt_s.cmd.sector = s_ff.cur_sect;
          nxt_s.cmd.data   = `FPE_ERASE_DATA;
          nxt_s.state      = ST_ERASE_WAIT;
        end else if (i_arr_done) begin
          nxt_s.sect_mask[s_ff.cur_sect] = 1'b0;
          if (nxt_s.sect_mask == 6'h00) begin
            ers_done = 1'b1;
          end else begin
            nxt_s.cur_sect = 3'(lowest({10'h000, nxt_s.sect_mask}));
            nxt_s.state    = ST_PREPROG;
          end
        end
      end
      ST_SUSP_WAIT: begin
        // The timer bounds the wait if the array never acknowledges the abort
        if (i_arr_done || tmr_expired) begin
          nxt_s.start   = 1'b0;
          nxt_s.in_susp = 1'b1;
          nxt_s.state   = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        if (start_req && !nxt_s.susp && s_ff.sect_ers) begin
          nxt_s.in_susp  = 1'b0;
          nxt_s.byte_pgm = 1'b0;
          nxt_s.state    = ST_PREPROG;
        end else if (start_req) begin
          nxt_s.start = 1'b0;
        end
      end
    endcase

    if (pg_done) begin
      nxt_s.start    = 1'b0;
      nxt_s.page_pgm = 1'b0;
      nxt_s.byte_pgm = 1'b0;
      nxt_s.protection_set_select     = 1'b0;
      nxt_s.eow      = 1'b1;
      nxt_s.state    = s_ff.in_susp ? ST_SUSPENDED : ST_IDLE;
    end
    if (ers_done) begin
      nxt_s.start    = 1'b0;
      nxt_s.chip_ers = 1'b0;
      nxt_s.sect_ers = 1'b0;
      nxt_s.eow      = 1'b1;
      nxt_s.state    = ST_IDLE;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s_ff       <= '0;
      s_ff.state <= ST_PWRUP;
      s_ff.start <= 1'(`FPE_FCR_RESET >> `FPE_B_START);
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_rsp                  = s_ff.rsp;
  assign o_arr_cmd              = s_ff.cmd;
  assign o_arr_raddr            = busy ? {s_ff.page_base[23:4], s_ff.idx} : i_req.addr;
  assign o_busy                 = busy;
  assign o_int                  = s_ff.isrc ? s_ff.eow : i_ext_int;
  assign o_wfi_powerdown        = s_ff.wait_lowpower_select;
  assign o_flash_write_active   = running;
  assign o_eeprom_update_refuse = running || s_ff.in_susp;

endmodule : fpe_flash_ctrl

// >>> tb/fpe_flash_ctrl_props.sv
// Port-level property checker for the flash sequencer
`timescale 1ns/1ns
`include "fpe_defines.svh"
module fpe_flash_ctrl_props import fpe_pkg::*; (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_reset,
  // Watched ports
  input  wire fpe_cpu_req_t  i_req,
  input  wire fpe_cpu_rsp_t  o_rsp,
  input  wire fpe_arr_cmd_t  o_arr_cmd,
  input  wire logic [23:0]   o_arr_raddr,
  input  wire logic [7:0]    i_arr_rdata,
  input  wire logic          i_eeprom_busy,
  input  wire logic          o_busy,
  input  wire logic          o_eeprom_update_refuse,
  input  wire logic          o_flash_write_active
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // Counts busy cycles after reset until the flag first drops
  logic [11:0] pu_cnt_ff;
  logic        pu_on_ff;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pu_cnt_ff <= 12'h000;
      pu_on_ff  <= 1'b1;
    end else if (pu_on_ff) begin
      pu_cnt_ff <= pu_cnt_ff + 12'h001;
      pu_on_ff  <= o_busy;
    end
  end

  a_rd_answer: assert property (i_req.rd |=> o_rsp.rvalid)
    else $error("read not answered next cycle");
  a_busy_blank: assert property (i_req.rd && o_busy && (i_req.addr <= `FPE_MAIN_END || i_req.addr[23:13] == 11'h118)
    |=> o_rsp.rdata == 8'hFF)
    else $error("flash read while busy not blanked");
  a_write_busy: assert property (o_flash_write_active |-> o_busy && o_eeprom_update_refuse)
    else $error("write running without busy or refuse");
  a_cmd_busy: assert property (o_arr_cmd.op != ARR_NONE |-> o_busy)
    else $error("array command issued while not busy");
  a_erase_ones: assert property (o_arr_cmd.op == ARR_ERASE |-> o_arr_cmd.data == 8'hFF)
    else $error("erase data not all ones");
  a_preprog_zero: assert property (o_arr_cmd.op == ARR_PREPROG |-> o_arr_cmd.data == 8'h00)
    else $error("preprogram data not all zeros");
  a_prog_clears: assert property (o_arr_cmd.op == ARR_PROG |->
    (o_arr_cmd.data & ~$past(i_arr_rdata)) == 8'h00 && o_arr_cmd.addr == $past(o_arr_raddr))
    else $error("program would set a bit");
  a_chip_rise: assert property (i_req.wr && i_req.addr == `FPE_FCR_ADDR && i_req.wdata == 8'hA0 && !o_busy
    && !o_eeprom_update_refuse && !i_eeprom_busy |=> o_busy)
    else $error("chip erase start did not raise busy");
  a_pwrup_bound: assert property (pu_cnt_ff <= 12'd2501)
    else $error("power-up busy too long");
endmodule : fpe_flash_ctrl_props

bind fpe_flash_ctrl fpe_flash_ctrl_props u_props (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_req(i_req),
  .o_rsp(o_rsp), .o_arr_cmd(o_arr_cmd), .o_arr_raddr(o_arr_raddr), .i_arr_rdata(i_arr_rdata),
  .i_eeprom_busy(i_eeprom_busy), .o_busy(o_busy), .o_eeprom_update_refuse(o_eeprom_update_refuse),
  .o_flash_write_active(o_flash_write_active));

// >>> tb/flash_program_erase_control_test.sv
// Self-checking bench for the flash sequencer with a behavioural array
`timescale 1ns/1ns
`include "fpe_defines.svh"
module flash_program_erase_control_test import fpe_pkg::*;;
  logic         i_core_clk = 1'b0;
  logic         i_reset = 1'b1;
  fpe_cpu_req_t i_req = '0;
  fpe_cpu_rsp_t o_rsp;
  fpe_arr_cmd_t o_arr_cmd;
  logic [23:0]  o_arr_raddr;
  logic [7:0]   i_arr_rdata = 8'hFF;
  logic         i_arr_done = 1'b0;
  logic         i_eeprom_busy = 1'b0;
  logic         i_powerdown = 1'b0;
  logic         i_ext_int = 1'b0;
  logic         o_busy, o_int, o_wfi_powerdown, o_eeprom_update_refuse, o_flash_write_active;
  int           mismatches = 0, n_tests = 0, dly = 0, mver = 0, a, n, base;
  logic [7:0]   mem[int];
  logic [7:0]   em[int];
  logic [7:0]   pb[int];
  logic [7:0]   rv, d;
  logic [5:0]   pre_seen = 6'h00;
  localparam logic [23:0] fcr_a = `FPE_FCR_ADDR;

  fpe_flash_ctrl dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_req(i_req), .o_rsp(o_rsp),
    .o_arr_cmd(o_arr_cmd), .o_arr_raddr(o_arr_raddr), .i_arr_rdata(i_arr_rdata), .i_arr_done(i_arr_done),
    .i_eeprom_busy(i_eeprom_busy), .i_powerdown(i_powerdown), .i_ext_int(i_ext_int), .o_busy(o_busy),
    .o_int(o_int), .o_wfi_powerdown(o_wfi_powerdown), .o_eeprom_update_refuse(o_eeprom_update_refuse),
    .o_flash_write_active(o_flash_write_active));

  always #2 i_core_clk = ~i_core_clk;

  function automatic int sect_of(int k);
    return (k < 'h2000) ? 0 : (k < 'h4000) ? 1 : (k < 'h1_0000) ? 2 : (k < 'h2_0000) ? 3 : (k < 'h3_0000) ? 4 : 5;
  endfunction : sect_of

  function automatic logic [7:0] ev(int k);
    return em.exists(k) ? em[k] : 8'hFF;
  endfunction : ev

  // Array model; erase is slow so a suspend lands mid-erase
  always @(o_arr_raddr or mver) i_arr_rdata = mem.exists(int'(o_arr_raddr)) ? mem[int'(o_arr_raddr)] : 8'hFF;
  always @(posedge i_core_clk) begin
    case (o_arr_cmd.op)
      ARR_PROG: begin
        mem[int'(o_arr_cmd.addr)] = i_arr_rdata & o_arr_cmd.data;
        dly = 3;
      end
      ARR_PREPROG: begin
        pre_seen[o_arr_cmd.sector] = 1'b1;
        dly = 3;
      end
      ARR_ERASE: begin
        foreach (mem[k]) if (k <= 'h3_FFFF && sect_of(k) == o_arr_cmd.sector) mem[k] = 8'hFF;
        dly = 300;
      end
      ARR_ABORT: dly = 2;
      default: ;
    endcase
    mver <= mver + 1;
  end
  always @(negedge i_core_clk) begin
    i_arr_done <= 1'b0;
    if (dly > 0) begin
      dly--;
      if (dly == 0) i_arr_done <= 1'b1;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [23:0] ad, input logic [7:0] dt);
    @(negedge i_core_clk);
    i_req = '{ad, dt, 1'b1, 1'b0};
    @(negedge i_core_clk);
    i_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [23:0] ad, output logic [7:0] dt);
    @(negedge i_core_clk);
    i_req = '{ad, 8'h00, 1'b0, 1'b1};
    @(negedge i_core_clk);
    i_req.rd = 1'b0;
    dt = o_rsp.rvalid ? o_rsp.rdata : 8'hXX;
  endtask : rd

  task automatic chk_rd(input int k);
    rd(k[23:0], rv);
    chk(rv, ev(k));
  endtask : chk_rd

  // Bounded wait for the busy flag to reach a level
  task automatic wait_busy(input logic lvl, input int lim);
    int c;
    c = 0;
    while (o_busy !== lvl && c < lim) begin
      @(negedge i_core_clk);
      c++;
    end
    chk({7'h00, o_busy}, {7'h00, lvl});
  endtask : wait_busy

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  initial begin
    #200000;
    mismatches++;
    results();
  end

  initial begin
    void'($urandom(87));
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_reset = 1'b0;
    rd(fcr_a, rv);
    chk(rv, 8'h01);
    chk_rd('h10);
    wait_busy(1'b0, 2500);
    wr(fcr_a, 8'h01);
    rd(fcr_a, rv);
    chk(rv, 8'h00);
    wr(`FPE_ECR_ADDR, 8'h06);
    rd(`FPE_ECR_ADDR, rv);
    chk(rv, 8'h06);
    chk({7'h00, o_wfi_powerdown}, 8'h01);
    wr(`FPE_ECR_ADDR, 8'h00);
    i_ext_int = 1'b1;
    @(negedge i_core_clk);
    chk({7'h00, o_int}, 8'h01);
    i_ext_int = 1'b0;
    // Same byte twice, so the second pass can only clear bits
    a = $urandom_range('h3_FFFF, 0);
    for (int p = 0; p < 2; p++) begin
      d = 8'($urandom);
      wr(fcr_a, 8'h10);
      wr(a[23:0], d);
      chk({7'h00, o_busy}, 8'h01);
      wr(fcr_a, 8'h90);
      wr(fcr_a, 8'h00);
      wait_busy(1'b0, 200);
      em[a] = ev(a) & d;
      chk_rd(a);
      rd(fcr_a, rv);
      chk(rv, 8'h00);
    end
    // Random page stores plus one outside the page, which must be dropped
    base = $urandom_range('h3FFE, 0) * 16;
    for (int p = 0; p < 2; p++) begin
      pb.delete();
      n = 1 + $urandom % 16;
      wr(fcr_a, 8'h40);
      for (int i = 0; i < n; i++) begin
        a = base + $urandom % 16;
        d = 8'($urandom);
        pb[a] = d;
        wr(a[23:0], d);
      end
      wr(base[23:0] + 24'h00_0010, 8'h00);
      wr(fcr_a, 8'hC0);
      wait_busy(1'b0, 400);
      foreach (pb[k]) em[k] = ev(k) & pb[k];
      for (int i = 0; i <= 16; i++) chk_rd(base + i);
    end
    // Two random protection stores; a repeated address keeps only its last store
    pb.delete();
    wr(fcr_a, 8'h02);
    for (int i = 0; i < 2; i++) begin
      a = 'h23_1FFC + $urandom % 4;
      d = 8'($urandom);
      wr(a[23:0], d);
      pb[a] = d;
    end
    wr(fcr_a, 8'h82);
    wait_busy(1'b0, 200);
    foreach (pb[k]) em[k] = ev(k) & pb[k];
    for (int i = 0; i < 4; i++) chk_rd('h23_1FFC + i);
    // Two-sector erase, suspended and resumed with a byte program between
    em['h2005] = 8'h00;
    mem['h2005] = 8'h00;
    pre_seen = 6'h00;
    wr(fcr_a, 8'h08);
    wr(24'h00_2005, 8'($urandom));
    wr(24'h01_0010, 8'($urandom));
    wr(fcr_a, 8'h88);
    repeat (60) @(negedge i_core_clk);
    wr(fcr_a, 8'h0C);
    wait_busy(1'b0, 3750);
    rd(fcr_a, rv);
    chk(rv, 8'h0C);
    chk({7'h00, o_eeprom_update_refuse}, 8'h01);
    d = 8'($urandom);
    wr(fcr_a, 8'h1C);
    wr(24'h00_0100, d);
    wr(fcr_a, 8'h9C);
    wait_busy(1'b0, 200);
    em['h100] = ev('h100) & d;
    chk_rd('h100);
    rd(fcr_a, rv);
    chk(rv, 8'h0C);
    wr(fcr_a, 8'h88);
    chk({7'h00, o_busy}, 8'h01);
    wait_busy(1'b0, 5000);
    foreach (em[k]) if (k <= 'h3_FFFF && (sect_of(k) == 1 || sect_of(k) == 3)) em[k] = 8'hFF;
    chk({2'b00, pre_seen}, 8'h0A);
    chk_rd('h2005);
    chk_rd('h100);
    // Chip erase refused while the other memory writes, then run
    i_eeprom_busy = 1'b1;
    wr(fcr_a, 8'hA0);
    chk({7'h00, o_busy}, 8'h00);
    i_eeprom_busy = 1'b0;
    pre_seen = 6'h00;
    wr(fcr_a, 8'hA0);
    chk({7'h00, o_busy}, 8'h01);
    wait_busy(1'b0, 4000);
    chk({2'b00, pre_seen}, 8'h3F);
    foreach (em[k]) if (k <= 'h3_FFFF) em[k] = 8'hFF;
    foreach (em[k]) chk_rd(k);
    rd(fcr_a, rv);
    chk(rv, 8'h00);
    i_powerdown = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_powerdown = 1'b0;
    repeat (2) @(negedge i_core_clk);
    chk({7'h00, o_busy}, 8'h01);
    wait_busy(1'b0, 2500);
    results();
  end
endmodule : flash_program_erase_control_test
